// ===== host_serial_model.sv
// host serial port model answering the device's frames
// assumes the device drives bit clock and frame sync, samples din falling
`timescale 1ns/1ns
module host_serial_model
  import sec_phase_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // serial link
  input wire serial_out_t pins,
  output logic din,
  // words sent and seen
  input wire logic [15:0] pri_word,
  input wire logic [15:0] sec_word,
  output logic [15:0] last_pri,
  output logic [15:0] rx_word,
  output logic rx_done,
  output logic rx_sec
);
  logic sclk_q, fs_q, req_q;
  logic [15:0] sh_q, cap_q;
  always_ff @(posedge aclk)
  begin
    sclk_q <= pins.sclk;
    fs_q <= pins.frame_sync_n;
    rx_done <= 1'b0;
    if (!aresetn)
    begin
      req_q <= 1'b0;
      din <= 1'b0;
      last_pri <= 16'h0000;
    end
    else if (fs_q && !pins.frame_sync_n)
    begin
      sh_q <= req_q ? sec_word : pri_word;
      din <= req_q ? sec_word[15] : pri_word[15];
      rx_sec <= req_q;
      last_pri <= req_q ? last_pri : pri_word;
      req_q <= !req_q && pri_word[1:0] == 2'b11;
    end
    else if (pins.frame_sync_n)
    begin
      // idle line toggles so a stale bit never passes for data
      din <= ~din;
      rx_done <= !fs_q;
      // last dout bit is still up on the edge that ends the frame
      rx_word <= {cap_q[14:0], pins.dout};
    end
    else if (pins.sclk && !sclk_q)
    begin
      sh_q <= {sh_q[14:0], 1'b0};
      din <= sh_q[14];
    end
    else if (!pins.sclk && sclk_q)
      cap_q <= {cap_q[14:0], pins.dout};
  end
endmodule : host_serial_model

// ===== sec_phase_defs.svh
// constants for the secondary phase adjust decoder: offsets, fields, timing
// assumes a 50 MHz aclk and a 32-bit AXI4-Lite register bus
`ifndef SEC_PHASE_DEFS_SVH
`define SEC_PHASE_DEFS_SVH

`define CLK_PERIOD_NS 20
`define SAMPLE_PERIOD_NS 125000
`define SAMPLE_PERIOD_CYC (`SAMPLE_PERIOD_NS / `CLK_PERIOD_NS)
`define SCLK_HALF_NS 200
`define SCLK_HALF_CYC ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCLK_EDGES_PER_BIT 2
`define FRAME_MARGIN_CYC 4

`define REG_PERIOD 8'h00
`define REG_PHASE 8'h04
`define REG_STATUS 8'h08
`define REG_DAC_RX 8'h0C
`define REG_CTRL_RX 8'h10

`define PHASE_RST 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define WORD_W 16
`define CMD_HI_BIT 15
`define CMD_LO_BIT 14
`define DAC_MSB 15
`define DAC_LSB 2
`define SEC_REQ_CODE 2'b11

`endif

// ===== sec_phase_monitor.sv
// port checker for the secondary phase adjust decoder
// assumes it is bound into secondary_phase_adjust_decode
`timescale 1ns/1ns
module sec_phase_monitor
  import sec_phase_pkg::*;
#(
  parameter int SCLK_HALF = 10
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // data side and serial pins
  input wire logic dac_valid,
  input wire logic sample_tick,
  input wire serial_out_t serial_pins
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [15:0] low_q;
  // length of the current low stretch of frame sync
  always_ff @(posedge aclk)
  begin
    if (!aresetn || serial_pins.frame_sync_n)
      low_q <= 16'h0000;
    else
      low_q <= low_q + 16'h0001;
  end
  property p_tick;
    sample_tick |=> !sample_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("tick too long");
  property p_dac;
    dac_valid |=> !dac_valid;
  endproperty
  a_dac: assert property (p_dac) else $error("dac pulse too long");
  property p_frame;
    $rose(serial_pins.frame_sync_n) |-> low_q == 16'(31 * SCLK_HALF);
  endproperty
  a_frame: assert property (p_frame) else $error("frame length");
  property p_start;
    $fell(serial_pins.frame_sync_n) |-> serial_pins.sclk;
  endproperty
  a_start: assert property (p_start) else $error("frame start clock");
  property p_idle;
    serial_pins.frame_sync_n |-> !serial_pins.sclk;
  endproperty
  a_idle: assert property (p_idle) else $error("clock runs idle");
  property p_tick_fs;
    sample_tick |=> $fell(serial_pins.frame_sync_n);
  endproperty
  a_tick_fs: assert property (p_tick_fs) else $error("no frame at tick");
  property p_b;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_b: assert property (p_b) else $error("late write answer");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && !s_axi_awready;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_r;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_r: assert property (p_r) else $error("late read answer");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_frame: cover property ($rose(serial_pins.frame_sync_n));
  c_dac: cover property (dac_valid);
endmodule : sec_phase_monitor

bind secondary_phase_adjust_decode sec_phase_monitor
  #(.SCLK_HALF(SCLK_HALF)) sec_phase_monitor_i (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .dac_valid, .sample_tick, .serial_pins);

// ===== sec_phase_pkg.sv
// types shared by the secondary phase adjust decoder and its helpers
// assumes sec_phase_defs.svh for the numeric constants
package sec_phase_pkg;

  typedef enum logic [2:0] {
    ACT_NONE    = 3'b001,
    ACT_LATER   = 3'b010,
    ACT_EARLIER = 3'b100
  } action_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRI  = 3'b010,
    ST_SEC  = 3'b100
  } frame_state_t;

  typedef struct packed {
    logic cmd_hi;
    logic cmd_lo;
    logic [13:0] rest;
  } sec_word_t;

  typedef struct packed {
    logic sclk;
    logic frame_sync_n;
    logic dout;
  } serial_out_t;

endpackage : sec_phase_pkg

// ===== secondary_phase_adjust_decode.sv
// sampling timer, primary and secondary frames, secondary command decode
// assumes an AXI4-Lite master on aclk and a frame-slaved serial host
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "sec_phase_defs.svh"
module secondary_phase_adjust_decode
  import sec_phase_pkg::*;
#(
  parameter int PERIOD_CYC = `SAMPLE_PERIOD_CYC,
  parameter int SCLK_HALF = `SCLK_HALF_CYC,
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // adc words to send
  input wire logic adc_valid,
  input wire logic [`WORD_W-1:0] adc_data,
  output logic adc_ready,
  // dac words received
  output logic [13:0] dac_word,
  output logic dac_valid,
  output logic sample_tick,
  // flag terminals and serial link
  input wire logic flag_terminal_hi,
  input wire logic flag_terminal_lo,
  output serial_out_t serial_pins,
  input wire logic din
);
  localparam int FRAME_CYC = `WORD_W * `SCLK_EDGES_PER_BIT * SCLK_HALF;
  localparam int MIN_PERIOD = 4 * FRAME_CYC + `FRAME_MARGIN_CYC;

  generate
    if (SCLK_HALF < 1 || PERIOD_CYC < MIN_PERIOD || PERIOD_CYC > 65535
        || ADDR_W < 5)
    begin : g_bad
      $error("period too short for two frames or parameters out of range");
    end
  endgenerate

  logic [15:0] period_q;
  logic [7:0] phase_q;
  logic [15:0] limit_q;
  logic [15:0] cnt_q;
  frame_state_t state_q;
  action_t last_action_q;
  logic sec_pending_q;
  logic [15:0] ctrl_rx_q;
  logic [13:0] dac_rx_q;

  // serial engine hookup
  logic start_q;
  logic [`WORD_W-1:0] tx_q;
  logic ser_busy, ser_done;
  logic [`WORD_W-1:0] ser_rx;

  // adc buffer drain side
  logic buf_valid, buf_pop;
  logic [`WORD_W-1:0] buf_data;

  // register bus state
  logic aw_have_q, w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;

  two_entry_buffer #(.WIDTH(`WORD_W), .DEPTH(2)) u_adc_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(adc_valid),
    .in_data(adc_data),
    .in_ready(adc_ready),
    .out_valid(buf_valid),
    .out_data(buf_data),
    .out_ready(buf_pop)
  );

  serial_word_shifter #(.HALF_CYC(SCLK_HALF)) u_shifter (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(start_q),
    .tx_word(tx_q),
    .busy(ser_busy),
    .done(ser_done),
    .rx_word(ser_rx),
    .pins(serial_pins),
    .din(din)
  );

  function automatic action_t decode(input sec_word_t w, input logic fh,
                                     input logic fl);
    action_t a;
    a = ACT_NONE;
    case ({w.cmd_hi, w.cmd_lo})
      2'b00: a = ACT_NONE;
      2'b01: a = ACT_LATER;
      2'b10: a = ACT_EARLIER;
      2'b11:
      begin
        case ({fh, fl})
          2'b01: a = ACT_LATER;
          2'b10: a = ACT_EARLIER;
          default: a = ACT_NONE;
        endcase
      end
      default: a = ACT_NONE;
    endcase
    return a;
  endfunction : decode

  // signed adjustment of one interval, clamped so both frames still fit
  function automatic logic [15:0] adjust(input logic [15:0] per,
                                         input logic [7:0] ph,
                                         input action_t a);
    logic signed [17:0] cand;
    logic signed [17:0] min_lim;
    cand = $signed({2'b00, per});
    min_lim = $signed({3'b000, per[15:1]}) + 18'(FRAME_CYC)
              + 18'(`FRAME_MARGIN_CYC);
    case (a)
      ACT_LATER: cand = cand + 18'($signed(ph));
      ACT_EARLIER: cand = cand - 18'($signed(ph));
      default: cand = cand;
    endcase
    if (cand < min_lim)
      cand = min_lim;
    if (cand > $signed(18'h0FFFF))
      cand = $signed(18'h0FFFF);
    return cand[15:0];
  endfunction : adjust

  logic wrap;
  logic at_half;
  logic [15:0] half;
  logic start_pri;
  logic start_sec;

  assign half = {1'b0, period_q[15:1]};
  assign wrap = ({1'b0, cnt_q} + 17'h00001) >= {1'b0, limit_q};
  assign at_half = (cnt_q == half);
  assign start_pri = (cnt_q == 16'h0000) && (state_q == ST_IDLE);
  assign start_sec = at_half && sec_pending_q && (state_q == ST_IDLE);
  assign buf_pop = start_pri && buf_valid;

  // sampling interval timer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= '0;
      limit_q <= 16'(PERIOD_CYC);
      sample_tick <= 1'b0;
    end
    else
    begin
      sample_tick <= (cnt_q == 16'h0000);
      if (wrap)
      begin
        cnt_q <= '0;
        limit_q <= period_q;
      end
      else
        cnt_q <= cnt_q + 16'h0001;
      // command lands before the end of the interval it shifts
      if (state_q == ST_SEC && ser_done)
        limit_q <= adjust(period_q, phase_q,
                          decode(sec_word_t'(ser_rx), flag_terminal_hi,
                                 flag_terminal_lo));
    end
  end

  // frame sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= ST_IDLE;
      start_q <= 1'b0;
      tx_q <= '0;
    end
    else
    begin
      start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (start_pri)
          begin
            state_q <= ST_PRI;
            start_q <= 1'b1;
            tx_q <= buf_valid ? buf_data : '0;
          end
          else if (start_sec)
          begin
            state_q <= ST_SEC;
            start_q <= 1'b1;
            tx_q <= '0;
          end
        end
        ST_PRI, ST_SEC:
        begin
          if (ser_done)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // received words and secondary bookkeeping
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sec_pending_q <= 1'b0;
      dac_rx_q <= '0;
      dac_word <= '0;
      dac_valid <= 1'b0;
      ctrl_rx_q <= '0;
      last_action_q <= ACT_NONE;
    end
    else
    begin
      dac_valid <= 1'b0;
      if (ser_done && state_q == ST_PRI)
      begin
        dac_rx_q <= ser_rx[`DAC_MSB:`DAC_LSB];
        dac_word <= ser_rx[`DAC_MSB:`DAC_LSB];
        dac_valid <= 1'b1;
        sec_pending_q <= (ser_rx[1:0] == `SEC_REQ_CODE);
      end
      if (ser_done && state_q == ST_SEC)
      begin
        sec_pending_q <= 1'b0;
        ctrl_rx_q <= ser_rx;
        last_action_q <= decode(sec_word_t'(ser_rx), flag_terminal_hi,
                                flag_terminal_lo);
      end
    end
  end

  // register bus: write address and data in either order, then response
  logic wr_map;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
  assign wr_map = (awaddr_q == ADDR_W'(`REG_PERIOD))
               || (awaddr_q == ADDR_W'(`REG_PHASE))
               || (awaddr_q == ADDR_W'(`REG_STATUS))
               || (awaddr_q == ADDR_W'(`REG_DAC_RX))
               || (awaddr_q == ADDR_W'(`REG_CTRL_RX));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // writable registers; a too-short period would starve the second frame
  logic [15:0] per_wr;
  assign per_wr = {wstrb_q[1] ? wdata_q[15:8] : period_q[15:8],
                   wstrb_q[0] ? wdata_q[7:0] : period_q[7:0]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_q <= 16'(PERIOD_CYC);
      phase_q <= `PHASE_RST;
    end
    else if (wr_fire)
    begin
      if (awaddr_q == ADDR_W'(`REG_PERIOD))
        period_q <= (per_wr < 16'(MIN_PERIOD)) ? 16'(MIN_PERIOD) : per_wr;
      if (awaddr_q == ADDR_W'(`REG_PHASE) && wstrb_q[0])
        phase_q <= wdata_q[7:0];
    end
  end

  // read side
  logic [31:0] rd_mux;
  logic rd_map;

  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_map = 1'b1;
    case (s_axi_araddr)
      ADDR_W'(`REG_PERIOD): rd_mux = {16'h0000, period_q};
      ADDR_W'(`REG_PHASE): rd_mux = {24'h000000, phase_q};
      ADDR_W'(`REG_STATUS):
        rd_mux = {24'h000000, buf_valid, state_q, sec_pending_q,
                  last_action_q};
      ADDR_W'(`REG_DAC_RX): rd_mux = {18'h00000, dac_rx_q};
      ADDR_W'(`REG_CTRL_RX): rd_mux = {16'h0000, ctrl_rx_q};
      default: rd_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule : secondary_phase_adjust_decode

// ===== secondary_phase_adjust_decode_tb.sv
// self-checking bench for the secondary phase adjust decoder
// assumes the host model on the serial side, an AXI4-Lite master here
`timescale 1ns/1ns
`include "sec_phase_defs.svh"
module secondary_phase_adjust_decode_tb
  import sec_phase_pkg::*;
;
  localparam int P = 1300;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, adc_valid = 1'b0;
  logic flag_terminal_hi = 1'b0, flag_terminal_lo = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [15:0] adc_data = 16'h0, pri_word = 16'h0, sec_word = 16'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, adc_ready, dac_valid, sample_tick, din;
  logic rx_done, rx_sec;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [13:0] dac_word;
  logic [15:0] last_pri, rx_word, q[$];
  serial_out_t serial_pins;
  int bad_count = 0, n_tests = 0, cyc = 0, since = 0, gap = 0;
  integer seed = 32'hCBE25D68;
  always #10 aclk = ~aclk;
  secondary_phase_adjust_decode #(.PERIOD_CYC(P), .SCLK_HALF(2))
    secondary_phase_adjust_decode_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_valid,
    .adc_data, .adc_ready, .dac_word, .dac_valid, .sample_tick,
    .flag_terminal_hi, .flag_terminal_lo, .serial_pins, .din);
  host_serial_model host_serial_model_i (.aclk, .aresetn,
    .pins(serial_pins), .din, .pri_word, .sec_word, .last_pri, .rx_word,
    .rx_done, .rx_sec);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready && s_axi_awvalid)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready && s_axi_arvalid)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  // leaves valid high so back-to-back pushes need no gap
  task automatic push(input logic [15:0] d, inout logic stall);
    adc_valid <= 1'b1;
    adc_data <= d;
    do
    begin
      @(posedge aclk);
      stall = stall | !adc_ready;
    end while (!adc_ready);
    q.push_back(d);
  endtask : push
  task automatic wait_tick;
    do
      @(posedge aclk);
    while (!sample_tick);
    @(posedge aclk);
  endtask : wait_tick
  function automatic int act(input logic [3:0] c);
    if (c[3:2] == 2'b01 || c == 4'hD)
      return 1;
    if (c[3:2] == 2'b10 || c == 4'hE)
      return -1;
    return 0;
  endfunction : act
  always @(posedge aclk)
  begin
    cyc++;
    since <= sample_tick ? 1 : since + 1;
    if (sample_tick)
      gap <= since;
    if (rx_done && rx_sec)
      chk(32'(rx_word), 32'h0);
    else if (rx_done)
      chk(32'(rx_word), 32'(q.size() ? q.pop_front() : 16'h0));
    if (dac_valid)
      chk(32'(dac_word), 32'(last_pri[15:2]));
    if (cyc == 60000)
    begin
      bad_count++;
      test_done();
    end
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] ph;
    logic [3:0] c;
    logic stall;
    logic [31:0] exp_act;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`REG_PERIOD, d, r);
    chk(d, P);
    rd(`REG_PHASE, d, r);
    chk(d, 32'h0);
    rd(8'h14, d, r);
    chk({d[29:0], r}, 32'(`RESP_SLVERR));
    wr(8'h14, 32'h5, r);
    chk(32'(r), 32'(`RESP_SLVERR));
    $display("register test done");
    wait_tick;
    repeat (100) @(posedge aclk);
    stall = 1'b0;
    repeat (3) push(16'($random(seed)), stall);
    adc_valid <= 1'b0;
    chk(32'(stall), 32'h1);
    $display("buffer test done");
    // nibbles: cmd hi, cmd lo, flag hi, flag lo
    for (int k = 0; k < 8; k++)
    begin
      c = 4'(32'h16BCDEF0 >> (4 * k));
      wait_tick;
      repeat (750) @(posedge aclk);
      ph = 8'($random(seed));
      wr(`REG_PHASE, {24'h0, ph}, r);
      {flag_terminal_hi, flag_terminal_lo} <= c[1:0];
      pri_word <= {14'($random(seed)), 2'b11};
      sec_word <= {c[3:2], 14'($random(seed))};
      stall = 1'b0;
      push(16'($random(seed)), stall);
      adc_valid <= 1'b0;
      wait_tick;
      repeat (100) @(posedge aclk);
      pri_word <= {14'($random(seed)), 2'b00};
      wait_tick;
      chk(32'(gap), 32'(P + act(c) * $signed(ph)));
      rd(`REG_STATUS, d, r);
      exp_act = act(c) > 0 ? 32'h2 : (act(c) < 0 ? 32'h4 : 32'h1);
      chk(32'(d[2:0]), exp_act);
      wait_tick;
      chk(32'(gap), 32'(P));
      $display("decode case %0d done", k);
    end
    test_done();
  end
endmodule : secondary_phase_adjust_decode_tb

// ===== serial_word_shifter.sv
// one 16-bit serial frame: frame sync low, bit clock, dout out, din in
// assumes din changes away from the falling bit-clock edge it is sampled on
`timescale 1ns/1ns
`include "sec_phase_defs.svh"
module serial_word_shifter
  import sec_phase_pkg::*;
#(
  parameter int HALF_CYC = 10
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frame request
  input wire logic start,
  input wire logic [`WORD_W-1:0] tx_word,
  output logic busy,
  output logic done,
  output logic [`WORD_W-1:0] rx_word,
  // serial pins
  output serial_out_t pins,
  input wire logic din
);
  logic [15:0] hcnt_q;
  logic [3:0] bit_q;
  logic [`WORD_W-1:0] tx_sh_q, rx_sh_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      rx_word <= '0;
      pins <= '{sclk: 1'b0, frame_sync_n: 1'b1, dout: 1'b0};
      hcnt_q <= '0;
      bit_q <= '0;
      tx_sh_q <= '0;
      rx_sh_q <= '0;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        busy <= 1'b1;
        pins <= '{sclk: 1'b1, frame_sync_n: 1'b0, dout: tx_word[`WORD_W-1]};
        tx_sh_q <= tx_word;
        hcnt_q <= '0;
        bit_q <= '0;
      end
      else if (busy)
      begin
        if (hcnt_q == 16'(HALF_CYC - 1))
        begin
          hcnt_q <= '0;
          pins.sclk <= ~pins.sclk;
          if (pins.sclk)
          begin
            rx_sh_q <= {rx_sh_q[`WORD_W-2:0], din};
            if (bit_q == 4'hF)
            begin
              busy <= 1'b0;
              done <= 1'b1;
              pins.frame_sync_n <= 1'b1;
              rx_word <= {rx_sh_q[`WORD_W-2:0], din};
            end
            else
              bit_q <= bit_q + 4'h1;
          end
          else
          begin
            tx_sh_q <= {tx_sh_q[`WORD_W-2:0], 1'b0};
            pins.dout <= tx_sh_q[`WORD_W-2];
          end
        end
        else
          hcnt_q <= hcnt_q + 16'h0001;
      end
    end
  end

endmodule : serial_word_shifter

// ===== two_entry_buffer.sv
// two-entry valid/ready buffer for ADC words waiting for a frame
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ns
module two_entry_buffer
  import sec_phase_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  generate
    if (DEPTH != 2 || WIDTH < 1)
    begin : g_bad
      $error("two_entry_buffer serves depth 2 only");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic wr_ptr_q, rd_ptr_q;
  logic [1:0] count_q, count_d;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != 2'd0);
  assign out_data = mem_q[rd_ptr_q];
  assign count_d = count_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q <= 2'd0;
      in_ready <= 1'b0;
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      // registered ready, low only while truly full and during reset
      in_ready <= (count_d != 2'd2);
      if (push)
        wr_ptr_q <= ~wr_ptr_q;
      if (pop)
        rd_ptr_q <= ~rd_ptr_q;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (push)
      mem_q[wr_ptr_q] <= in_data;
  end

endmodule : two_entry_buffer
